// ### design/cks_clock_status.sv
// Clock controller status, start flags and pending interrupt read-out
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cks_params.svh"

module cks_clock_status
   import cks_pkg::*;
#(
   parameter int LF_SRC_W = 2
)
(
   // Clock and reset
   input  wire  logic                mclk,
   input  wire  logic                rst,
   // APB slave
   input  wire  logic [11:0]         paddr,
   input  wire  logic                psel,
   input  wire  logic                penable,
   input  wire  logic                pwrite,
   input  wire  logic [31:0]         pwdata,
   output var   logic [31:0]         prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Oscillator reports, asynchronous levels
   input  wire  cks_osc_s            mainHfClockIn,
   input  wire  cks_osc_s            lowFreqClockIn,
   input  wire  cks_osc_s            audioClockIn,
   // Configured source selection of the low-frequency clock
   input  wire  logic [LF_SRC_W-1:0] lowFreqSourceSelect,
   // Event pulses, same clock
   input  wire  cks_evt_s            eventIn,
   // Start task pulses to oscillator control
   output var   logic                mainHfStartTask,
   output var   logic                lowFreqStartTask,
   output var   logic                audioStartTask,
   output var   logic                fastClockStartTask,
   // Interrupt
   output logic                      irq
);

   // ==========================================================
   // Input synchronisers
   cks_osc_s mainMeta_ff;
   cks_osc_s mainSync_ff;
   cks_osc_s lfMeta_ff;
   cks_osc_s lfSync_ff;
   cks_osc_s audMeta_ff;
   cks_osc_s audSync_ff;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mainMeta_ff <= '0;
         mainSync_ff <= '0;
         lfMeta_ff   <= '0;
         lfSync_ff   <= '0;
         audMeta_ff  <= '0;
         audSync_ff  <= '0;
      end
      else
      begin
         mainMeta_ff <= mainHfClockIn;
         mainSync_ff <= mainMeta_ff;
         lfMeta_ff   <= lowFreqClockIn;
         lfSync_ff   <= lfMeta_ff;
         audMeta_ff  <= audioClockIn;
         audSync_ff  <= audMeta_ff;
      end
   end

   // ==========================================================
   // Bus decode
   logic accSetup;
   logic accDone;
   logic wrDone;

   assign accSetup = psel & ~penable;
   assign accDone  = psel & penable;
   assign wrDone   = accDone & pwrite;
   assign pready   = 1'b1;

   function automatic logic wrHit(input logic [11:0] ofs);
      wrHit = wrDone & (paddr == ofs);
   endfunction

   function automatic logic taskHit(input logic [11:0] ofs);
      taskHit = wrHit(ofs) & pwdata[0];
   endfunction

   // ==========================================================
   // Start tasks
   logic taskMain;
   logic taskLf;
   logic taskAudio;
   logic taskFast;

   assign taskMain  = taskHit(`CKS_TASK_MAIN_OFS);
   assign taskLf    = taskHit(`CKS_TASK_LF_OFS);
   assign taskAudio = taskHit(`CKS_TASK_AUDIO_OFS);
   assign taskFast  = taskHit(`CKS_TASK_FAST_OFS);

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mainHfStartTask    <= 1'b0;
         lowFreqStartTask   <= 1'b0;
         audioStartTask     <= 1'b0;
         fastClockStartTask <= 1'b0;
      end
      else
      begin
         mainHfStartTask    <= taskMain;
         lowFreqStartTask   <= taskLf;
         audioStartTask     <= taskAudio;
         fastClockStartTask <= taskFast;
      end
   end

   // ==========================================================
   // Start requested flags
   logic mainRun_ff;
   logic lfRun_ff;
   logic audioRun_ff;
   logic fastRun_ff;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mainRun_ff  <= 1'b0;
         lfRun_ff    <= 1'b0;
         audioRun_ff <= 1'b0;
         fastRun_ff  <= 1'b0;
      end
      else
      begin
         mainRun_ff  <= mainRun_ff | taskMain;
         lfRun_ff    <= lfRun_ff | taskLf;
         audioRun_ff <= audioRun_ff | taskAudio;
         fastRun_ff  <= fastRun_ff | taskFast;
      end
   end

   // ==========================================================
   // Low-frequency source snapshot
   logic [LF_SRC_W-1:0] lfCopy_ff;

   always_ff @(posedge mclk)
   begin
      if (rst)
         lfCopy_ff <= '0;
      else if (taskLf)
         lfCopy_ff <= lowFreqSourceSelect;
   end

   // ==========================================================
   // Status words, built only from this instance's inputs
   function automatic logic [31:0] statWord(input cks_osc_s s, input logic [1:0] srcMask);
      logic [31:0] w;
      w = `CKS_WORD_RESET;
      w[`CKS_SRC_BIT +: 2]  = s.source & srcMask;
      w[`CKS_FORCED_BIT]    = s.forced;
      w[`CKS_STATE_BIT]     = s.running;
      statWord = w;
   endfunction

   logic [31:0] mainStat;
   logic [31:0] lfStat;
   logic [31:0] audStat;

   assign mainStat = statWord(mainSync_ff, 2'h1);
   assign lfStat   = statWord(lfSync_ff, 2'h3);
   assign audStat  = statWord(audSync_ff, 2'h3);

   // ==========================================================
   // Events and interrupts
   cks_evt_t evtStatus_ff;
   cks_evt_t intEnable_ff;
   cks_evt_t pending;
   cks_evt_t evtIn;

   assign evtIn   = cks_evt_t'(eventIn);
   assign pending = evtStatus_ff & intEnable_ff;
   assign irq     = |pending;

   always_ff @(posedge mclk)
   begin
      if (rst)
         evtStatus_ff <= `CKS_EVT_RESET;
      else if (wrHit(`CKS_EVT_STATUS_OFS))
         evtStatus_ff <= (evtStatus_ff & ~pwdata[4:0]) | evtIn;
      else
         evtStatus_ff <= evtStatus_ff | evtIn;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         intEnable_ff <= `CKS_EVT_RESET;
      else if (wrHit(`CKS_INT_SET_OFS))
         intEnable_ff <= intEnable_ff | pwdata[4:0];
      else if (wrHit(`CKS_INT_CLR_OFS))
         intEnable_ff <= intEnable_ff & ~pwdata[4:0];
   end

   // ==========================================================
   // Read mux, sampled in the setup phase
   logic [31:0] rdData;
   logic        rdMapped;

   always_comb
   begin
      rdData   = `CKS_WORD_RESET;
      rdMapped = 1'b1;
      case (paddr)
         `CKS_TASK_MAIN_OFS,
         `CKS_TASK_LF_OFS,
         `CKS_TASK_AUDIO_OFS,
         `CKS_TASK_FAST_OFS:  rdData = `CKS_WORD_RESET;
         `CKS_EVT_STATUS_OFS: rdData = {27'h0, evtStatus_ff};
         `CKS_INT_SET_OFS,
         `CKS_INT_CLR_OFS:    rdData = {27'h0, intEnable_ff};
         `CKS_PENDING_OFS:    rdData = {27'h0, pending};
         `CKS_MAIN_RUN_OFS:   rdData = {31'h0, mainRun_ff};
         `CKS_MAIN_STAT_OFS:  rdData = mainStat;
         `CKS_LF_RUN_OFS:     rdData = {31'h0, lfRun_ff};
         `CKS_LF_STAT_OFS:    rdData = lfStat;
         `CKS_LF_COPY_OFS:    rdData = 32'(lfCopy_ff);
         `CKS_AUDIO_RUN_OFS:  rdData = {31'h0, audioRun_ff};
         `CKS_AUDIO_STAT_OFS: rdData = audStat;
         `CKS_FAST_RUN_OFS:   rdData = {31'h0, fastRun_ff};
         default:             rdMapped = 1'b0;
      endcase
   end

   logic mapped_ff;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         prdata    <= `CKS_WORD_RESET;
         mapped_ff <= 1'b1;
      end
      else if (accSetup)
      begin
         prdata    <= pwrite ? `CKS_WORD_RESET : rdData;
         mapped_ff <= rdMapped;
      end
   end

   assign pslverr = accDone & ~mapped_ff;

endmodule // cks_clock_status

`default_nettype wire

// ### design/cks_params.svh
// Offsets, field positions, reset values and behaviour list of the clock status block
// Behaviour
// - Writing one to an enable-set bit enables that event's interrupt; zero leaves it.
// - Main clock start flag sets once software triggers the main clock start task.
// - Main clock status word reports source, forced run and running, reset zero.
// - Main clock source field reads zero when the internal oscillator drives it.
// - Main clock source field reads one when the crystal oscillator drives it.
// - Forced run reads one only when forced, running bit reads one only while running.
// - Status words reflect only this instance's own configuration and actions; the code shows the synchronised oscillator reports ungated.
// - Low-frequency start flag sets once software triggers its start task.
// - Low-frequency status word reports the source currently driving that clock.
// - Source selection is copied at the low-frequency start and held until the next.
// - Audio start flag sets once software triggers the audio start task.
// - Audio status word reports the source currently driving the audio clock.
// - Fast clock start flag sets once software triggers the fast clock start task.
`ifndef CKS_PARAMS_SVH
`define CKS_PARAMS_SVH

// ==========================================================
// Register offsets
`define CKS_TASK_MAIN_OFS   12'h000
`define CKS_TASK_LF_OFS     12'h004
`define CKS_TASK_AUDIO_OFS  12'h008
`define CKS_TASK_FAST_OFS   12'h00C
`define CKS_EVT_STATUS_OFS  12'h100
`define CKS_INT_SET_OFS     12'h304
`define CKS_INT_CLR_OFS     12'h308
`define CKS_PENDING_OFS     12'h30C
`define CKS_MAIN_RUN_OFS    12'h408
`define CKS_MAIN_STAT_OFS   12'h40C
`define CKS_LF_RUN_OFS      12'h414
`define CKS_LF_STAT_OFS     12'h418
`define CKS_LF_COPY_OFS     12'h41C
`define CKS_AUDIO_RUN_OFS   12'h450
`define CKS_AUDIO_STAT_OFS  12'h454
`define CKS_FAST_RUN_OFS    12'h458

// ==========================================================
// Field positions
`define CKS_SRC_BIT         0
`define CKS_FORCED_BIT      4
`define CKS_STATE_BIT       16
`define CKS_EVT_MAIN_BIT    0
`define CKS_EVT_LF_BIT      1
`define CKS_EVT_CAL_BIT     2
`define CKS_EVT_AUDIO_BIT   3
`define CKS_EVT_FAST_BIT    4

// ==========================================================
// Reset values
`define CKS_WORD_RESET      32'h0000_0000
`define CKS_EVT_RESET       5'h00

`endif

// ### design/cks_pkg.sv
// Types shared by the clock status block
`default_nettype none
package cks_pkg;

   // Oscillator report of one clock
   typedef struct packed {
      logic       running;
      logic       forced;
      logic [1:0] source;
   } cks_osc_s;

   // Event pulses from the oscillator control
   typedef struct packed {
      logic fastStarted;
      logic audioStarted;
      logic calDone;
      logic lfStarted;
      logic mainStarted;
   } cks_evt_s;

   typedef logic [4:0] cks_evt_t;

endpackage

`default_nettype wire

// ### dv/cks_clock_status_asserts.sv
// Port-level assertions of the clock status block
`timescale 1ns/100ps
`default_nettype none
module cks_clock_status_asserts #(parameter int LF_SRC_W = 2)
(
   // Clock, reset and bus
   input wire logic mclk,
   input wire logic rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Block side
   input wire logic [LF_SRC_W-1:0] lowFreqSourceSelect,
   input wire logic mainHfStartTask,
   input wire logic lowFreqStartTask,
   input wire logic audioStartTask,
   input wire logic fastClockStartTask,
   input wire logic irq
);
   // ==========
   // Checks
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic wr, rd, runFlag_ff;
   logic [LF_SRC_W-1:0] lfCopy_ff;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   // Expected run flag and source copy
   always_ff @(posedge mclk)
      if (rst)
         runFlag_ff <= 1'b0;
      else if (wr && paddr == 12'h000 && pwdata[0])
         runFlag_ff <= 1'b1;
   always_ff @(posedge mclk)
      if (rst)
         lfCopy_ff <= '0;
      else if (wr && paddr == 12'h004 && pwdata[0])
         lfCopy_ff <= lowFreqSourceSelect;
   property p_taskMain;
      mainHfStartTask == $past(wr && paddr == 12'h000 && pwdata[0]);
   endproperty
   a_taskMain: assert property (p_taskMain) else $error("main pulse");
   property p_taskLf;
      lowFreqStartTask == $past(wr && paddr == 12'h004 && pwdata[0]);
   endproperty
   a_taskLf: assert property (p_taskLf) else $error("lf pulse");
   property p_taskAudio;
      wr && paddr == 12'h008 && pwdata[0] |=> audioStartTask;
   endproperty
   a_taskAudio: assert property (p_taskAudio) else $error("audio pulse");
   property p_taskFast;
      wr && paddr == 12'h00C && pwdata[0] |=> fastClockStartTask;
   endproperty
   a_taskFast: assert property (p_taskFast) else $error("fast pulse");
   property p_pending;
      rd && paddr == 12'h30C |-> (prdata != 32'h0) == $past(irq);
   endproperty
   a_pending: assert property (p_pending) else $error("pending");
   property p_runMain;
      rd && paddr == 12'h408 |-> prdata[0] == runFlag_ff;
   endproperty
   a_runMain: assert property (p_runMain) else $error("run flag");
   property p_mainStat;
      rd && paddr == 12'h40C |-> (prdata & 32'hFFFE_FFEE) == 32'h0;
   endproperty
   a_mainStat: assert property (p_mainStat) else $error("main stat");
   property p_lfCopy;
      rd && paddr == 12'h41C |-> prdata == 32'(lfCopy_ff);
   endproperty
   a_lfCopy: assert property (p_lfCopy) else $error("lf copy");
endmodule // cks_clock_status_asserts
bind cks_clock_status cks_clock_status_asserts #(.LF_SRC_W(LF_SRC_W)) i_chk (.mclk, .rst,
   .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .lowFreqSourceSelect, .mainHfStartTask,
   .lowFreqStartTask, .audioStartTask, .fastClockStartTask, .irq);
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench of the clock status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin nFail++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
   import cks_pkg::*;
   // ==========
   // Bench
   logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'h697F;
   logic pready, pslverr, irq, tM, tL, tA, tF;
   logic [1:0] lfSel = 2'h0;
   cks_osc_s mainIn = '0, lfIn = '0, audIn = '0;
   cks_evt_s evt = '0;
   logic [32:0] expQ[$], e;
   logic [11:0] adr[9] = '{12'h30C, 12'h408, 12'h40C, 12'h414, 12'h418, 12'h41C, 12'h450,
      12'h454, 12'h458};
   logic [11:0] runA[4] = '{12'h408, 12'h414, 12'h450, 12'h458};
   int nFail = 0, checkCount = 0;
   always #2.5 mclk = ~mclk;
   cks_clock_status #(.LF_SRC_W(2)) i_cks_clock_status (.mclk(mclk), .rst(rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mainHfClockIn(mainIn), .lowFreqClockIn(lfIn),
      .audioClockIn(audIn), .lowFreqSourceSelect(lfSel), .eventIn(evt), .mainHfStartTask(tM),
      .lowFreqStartTask(tL), .audioStartTask(tA), .fastClockStartTask(tF), .irq(irq));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] stw(cks_osc_s o, logic m);
      return {15'h0, o.running, 11'h0, o.forced, 2'h0, o.source[1] & ~m, o.source[0]};
   endfunction
   task automatic testDone();
      $display("checks %0d failures %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] x);
      int n;
      n = 0;
      if (!w)
         expQ.push_back(x);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n++ < 20)
         @(posedge mclk);
      if (n > 20)
      begin
         nFail++;
         testDone();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] v);
      apb(1'b0, a, 32'h0, {1'b0, v});
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   // Compares each read against the oldest expectation
   always @(posedge mclk)
      if (psel && penable && !pwrite && pready)
      begin
         e = expQ.pop_front();
         `CHK("read", e, {pslverr, prdata})
      end
   initial
   begin
      logic [1:0] cp;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      foreach (adr[i])
         rd(adr[i], 32'h0);
      apb(1'b0, 12'h200, 32'h0, {1'b1, 32'h0});
      $display("reset test done");
      for (int i = 0; i < 4; i++)
      begin
         lfSel <= 2'(xs());
         wr(12'(4 * i), xs() | 32'h1);
         if (i == 1)
            cp = lfSel;
         rd(runA[i], 32'h1);
      end
      rd(12'h41C, {30'h0, cp});
      $display("start test done");
      for (int j = 0; j < 8; j++)
      begin
         mainIn <= cks_osc_s'(4'(xs()));
         lfIn <= cks_osc_s'(4'(xs()));
         audIn <= cks_osc_s'(4'(xs()));
         repeat (3) @(posedge mclk);
         rd(12'h40C, stw(mainIn, 1'b1));
         rd(12'h418, stw(lfIn, 1'b0));
         rd(12'h454, stw(audIn, 1'b0));
      end
      $display("status test done");
      wr(12'h304, 32'h15);
      wr(12'h304, 32'h0);
      rd(12'h304, 32'h15);
      evt <= cks_evt_s'(5'h1F);
      @(posedge mclk);
      evt <= '0;
      @(posedge mclk);
      `CHK("irq", 1'b1, irq)
      rd(12'h30C, 32'h15);
      wr(12'h308, 32'h1F);
      rd(12'h30C, 32'h0);
      `CHK("irq", 1'b0, irq)
      wr(12'h100, 32'h1F);
      rd(12'h100, 32'h0);
      $display("interrupt test done");
      testDone();
   end
endmodule // tb
`default_nettype wire
